// ---- test/tlsp_top_bench.sv ----
`timescale 1ns/100ps
module tlsp_top_bench;
	import tlsp_pkg::*;
	// ******************************************
	// stimulus and observed signals
	// ******************************************
	logic clk_i;
	logic rst_i;
	logic cyc_i;
	logic stb_i;
	logic we_i;
	logic [9:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic ack_o;
	logic hi_lvl;
	logic lo_lvl;
	logic rw_gr;
	logic rd_gr;
	logic recall_i;
	logic [1:0] recall_dest_i;
	logic [7:0] recall_addr_i;
	logic [7:0] recall_data_i;
	logic [7:0] tix;
	logic [7:0] step_hi;
	logic [7:0] step_lo;
	logic [15:0] mod_o;
	logic [15:0] aux1_o;
	logic [15:0] aux2_o;
	logic [7:0] step_o;
	logic [15:0] exp_out [0:2];
	logic [31:0] rd;
	int miscompares;
	int n_checks;

	tlsp_top #(.STEP_W(8)) tlsp_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.higher_password_level_i(hi_lvl), .lower_password_level_i(lo_lvl),
		.low_level_table_rw_grant_i(rw_gr), .low_level_table_read_grant_i(rd_gr),
		.recall_i(recall_i), .recall_dest_i(recall_dest_i), .recall_addr_i(recall_addr_i),
		.recall_data_i(recall_data_i), .temperature_table_index_i(tix),
		.bias_step_high_value_i(step_hi), .bias_step_low_value_i(step_lo), .modulation_o(mod_o),
		.aux_analog_out_one_o(aux1_o), .aux_analog_out_two_o(aux2_o), .active_bias_step_o(step_o));

	// ******************************************
	// shared tasks
	// ******************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task end_sim;
		if (miscompares == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// one classic cycle; waits for ack as long as it takes, the watchdog ends a hang
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		sel_i <= s;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb

	task automatic lv(input logic h, input logic l, input logic rw, input logic r);
		@(posedge clk_i);
		hi_lvl <= h;
		lo_lvl <= l;
		rw_gr <= rw;
		rd_gr <= r;
	endtask : lv

	// pulses one recall, predicts the byte placement and compares the three destination outputs
	task automatic recall(input logic [1:0] dst, input logic [7:0] t, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] bnd, input logic pol);
		logic up;
		up = (((dst == 2'd0) ? t : a) >= bnd) ^ pol;
		if (dst != 2'd3 && up) exp_out[dst][15:8] = d;
		if (dst != 2'd3 && !up) exp_out[dst][7:0] = d;
		@(posedge clk_i);
		recall_i <= 1'b1;
		recall_dest_i <= dst;
		tix <= t;
		recall_addr_i <= a;
		recall_data_i <= d;
		@(posedge clk_i);
		recall_i <= 1'b0;
		#1;
		check({16'h0000, mod_o}, {16'h0000, exp_out[0]}, "modulation");
		check({16'h0000, aux1_o}, {16'h0000, exp_out[1]}, "aux one");
		check({16'h0000, aux2_o}, {16'h0000, exp_out[2]}, "aux two");
		// the status word reports which byte the last recall used
		if (dst != 2'd3) begin
			wb(1'b0, TLSP_IDX_STATUS, 8'h00, 4'hf);
			check({31'h0, rd[TLSP_STAT_UPPER_LSB + dst]}, {31'h0, up}, "placement status");
		end
	endtask : recall

	// ******************************************
	// scenarios
	// ******************************************
	task automatic test_access;
		lv(1'b1, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, TLSP_IDX_MOD_BND + 8'(i), 8'h00, 4'hf);
			check(rd, 32'h0, "reset value");
		end
		wb(1'b1, TLSP_IDX_MOD_BND, 8'h5a, 4'hf);
		lv(1'b0, 1'b1, 1'b0, 1'b0);
		wb(1'b1, TLSP_IDX_MOD_BND, 8'h11, 4'hf);
		wb(1'b0, TLSP_IDX_MOD_BND, 8'h00, 4'hf);
		check(rd, 32'h0, "read without grant");
		lv(1'b0, 1'b1, 1'b0, 1'b1);
		wb(1'b1, TLSP_IDX_MOD_BND, 8'h22, 4'hf);
		wb(1'b0, TLSP_IDX_MOD_BND, 8'h00, 4'hf);
		check(rd, 32'h5a, "read grant only");
		lv(1'b0, 1'b1, 1'b1, 1'b0);
		wb(1'b1, TLSP_IDX_MOD_BND, 8'h33, 4'hf);
		wb(1'b0, TLSP_IDX_MOD_BND, 8'h00, 4'hf);
		check(rd, 32'h33, "rw grant");
		lv(1'b0, 1'b0, 1'b1, 1'b1);
		wb(1'b0, TLSP_IDX_MOD_BND, 8'h00, 4'hf);
		check(rd, 32'h0, "no level");
		lv(1'b1, 1'b0, 1'b0, 1'b0);
		wb(1'b1, TLSP_IDX_POLARITY, 8'hff, 4'hf);
		wb(1'b0, TLSP_IDX_POLARITY, 8'h00, 4'hf);
		check(rd, 32'he0, "polarity reserved bits");
		wb(1'b1, TLSP_IDX_AUX1_BND, 8'ha5, 4'he);
		wb(1'b0, TLSP_IDX_AUX1_BND, 8'h00, 4'hf);
		check(rd, 32'h0, "write without low lane");
		wb(1'b0, 8'hff, 8'h00, 4'hf);
		check(rd, 32'h0, "unmapped read");
	endtask : test_access

	// every destination, both polarities, boundary minus one, equal and plus one
	task automatic test_place;
		logic [7:0] bnd [0:2];
		logic [7:0] c;
		bnd[0] = 8'h90;
		bnd[1] = 8'ha0;
		bnd[2] = 8'hb0;
		for (int i = 0; i < 3; i++) wb(1'b1, TLSP_IDX_MOD_BND + 8'(i), bnd[i], 4'hf);
		for (int p = 0; p < 2; p++) begin
			wb(1'b1, TLSP_IDX_POLARITY, (p != 0) ? 8'he0 : 8'h00, 4'hf);
			for (int dst = 0; dst < 3; dst++) begin
				for (int k = 0; k < 3; k++) begin
					c = bnd[dst] + 8'(k) - 8'h01;
					// the comparison not used is driven with the complement, below every boundary
					recall(2'(dst), (dst == 0) ? c : ~c, (dst == 0) ? ~c : c, 8'(8'h31 + 16 * k + 4 * dst + p),
						bnd[dst], p[0]);
				end
			end
		end
		recall(2'd3, 8'h00, 8'h00, 8'hee, 8'h00, 1'b0);
	endtask : test_place

	task automatic test_step;
		logic [7:0] ts [0:4];
		ts = '{8'h91, 8'h90, 8'h8f, 8'hff, 8'h00};
		wb(1'b1, TLSP_IDX_STEP_BND, 8'h90, 4'hf);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i);
			tix <= ts[i];
			repeat (2) @(posedge clk_i);
			#1;
			check({24'h0, step_o}, {24'h0, (ts[i] > 8'h90) ? step_hi : step_lo}, "bias step");
			wb(1'b0, TLSP_IDX_STATUS, 8'h00, 4'hf);
			check({31'h0, rd[TLSP_STAT_STEP_BIT]}, {31'h0, (ts[i] > 8'h90)}, "step status");
		end
	endtask : test_step

	// ******************************************
	// clock, watchdog and main sequence
	// ******************************************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// cuts a hang short well past the expected run length
	initial begin
		#(40 * 20000);
		miscompares++;
		end_sim;
	end

	initial begin
		miscompares = 0;
		n_checks = 0;
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, hi_lvl, lo_lvl, rw_gr, rd_gr, recall_i} = 8'h00;
		adr_i = 10'h000;
		sel_i = 4'h0;
		dat_i = 32'h0;
		recall_dest_i = 2'd0;
		recall_addr_i = 8'h00;
		recall_data_i = 8'h00;
		tix = 8'h00;
		step_hi = 8'hc3;
		step_lo = 8'h3c;
		for (int i = 0; i < 3; i++) exp_out[i] = 16'h0000;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		test_access;
		test_place;
		test_step;
		end_sim;
	end
endmodule : tlsp_top_bench

// ---- verilog/tlsp_pkg.sv ----
package tlsp_pkg;
	// ******************************************
	// register indices (byte address is four times the index)
	// ******************************************
	localparam logic [7:0] TLSP_IDX_MOD_BND = 8'hc2;
	localparam logic [7:0] TLSP_IDX_AUX1_BND = 8'hc3;
	localparam logic [7:0] TLSP_IDX_AUX2_BND = 8'hc4;
	localparam logic [7:0] TLSP_IDX_STEP_BND = 8'hc5;
	localparam logic [7:0] TLSP_IDX_POLARITY = 8'hc6;
	localparam logic [7:0] TLSP_IDX_STATUS = 8'he0;
	// ******************************************
	// reset values and field positions
	// ******************************************
	localparam logic [7:0] TLSP_RST_BND = 8'h00;
	localparam logic [7:0] TLSP_RST_POLARITY = 8'h00;
	localparam int TLSP_POL_MOD_BIT = 7;
	localparam int TLSP_POL_AUX1_BIT = 6;
	localparam int TLSP_POL_AUX2_BIT = 5;
	localparam logic [7:0] TLSP_POL_WR_MASK = 8'he0;
	localparam int TLSP_STAT_STEP_BIT = 0;
	localparam int TLSP_STAT_UPPER_LSB = 1;
	// ******************************************
	// encoding of boundary bytes
	// ******************************************
	localparam logic [7:0] TLSP_BND_OFFSET = 8'h80;
	localparam int TLSP_BND_TEMP_SHIFT_C = 40;
	localparam int TLSP_MOD_STEP_C = 2;
	localparam int TLSP_AUX_STEP_C = 4;
	// ******************************************
	// recall destinations
	// ******************************************
	typedef enum logic [1:0] {
		TLSP_DEST_MOD = 2'b00,
		TLSP_DEST_AUX1 = 2'b01,
		TLSP_DEST_AUX2 = 2'b10
	} tlsp_dest_e;
	localparam int TLSP_NUM_DEST = 3;
endpackage : tlsp_pkg

// ---- verilog/tlsp_place.sv ----
`timescale 1ns/100ps
module tlsp_place
	import tlsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic store_i,
	input wire logic [7:0] value_i,
	input wire logic [7:0] compare_i,
	input wire logic [7:0] boundary_i,
	input wire logic polarity_i,
	output logic [15:0] dest_o,
	output logic upper_o
);
	logic at_or_above;
	logic to_upper;

	// below the boundary goes low unless polarity reverses it
	assign at_or_above = (compare_i >= boundary_i);
	assign to_upper = at_or_above ^ polarity_i; // [RULE6] [RULE7] [RULE8] [RULE9]

	// one byte of the destination changes per recall, the other holds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dest_o <= 16'h0000;
			upper_o <= 1'b0;
		end else if (store_i) begin
			upper_o <= to_upper;
			if (to_upper) begin
				dest_o[15:8] <= value_i;
			end else begin
				dest_o[7:0] <= value_i;
			end
		end
	end

	// ******************************************
	// checks
	// ******************************************
	byte_lands_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		store_i && (compare_i < boundary_i) && !polarity_i |=> dest_o[7:0] == $past(value_i))
		else $error("below boundary value not stored low");
	byte_reversed_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
		store_i && polarity_i |=> dest_o[15:8] == $past(dest_o[15:8]) || dest_o[7:0] == $past(dest_o[7:0]))
		else $error("both bytes changed in one recall");
	hold_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		!store_i |=> $stable(dest_o))
		else $error("destination changed without recall");
	cov_upper_c: cover property (@(posedge clk_i) disable iff (rst_i) store_i && to_upper);
endmodule : tlsp_place

// ---- verilog/tlsp_step_sel.sv ----
`timescale 1ns/100ps
module tlsp_step_sel
	import tlsp_pkg::*;
#(
	parameter int STEP_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] index_i,
	input wire logic [7:0] boundary_i,
	input wire logic [STEP_W-1:0] high_i,
	input wire logic [STEP_W-1:0] low_i,
	output logic [STEP_W-1:0] step_o,
	output logic high_sel_o
);
	// strictly above picks the high step; equal falls to the low step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_o <= '0;
			high_sel_o <= 1'b0;
		end else begin
			high_sel_o <= (index_i > boundary_i); // [RULE5] [RULE11]
			step_o <= (index_i > boundary_i) ? high_i : low_i; // [RULE5]
		end
	end

	step_high_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
		index_i > boundary_i |=> step_o == $past(high_i) && high_sel_o)
		else $error("high step not chosen above boundary");
	step_equal_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
		index_i <= boundary_i |=> step_o == $past(low_i) && !high_sel_o)
		else $error("low step not chosen at or below boundary");
	cov_step_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(high_sel_o));
endmodule : tlsp_step_sel

// ---- verilog/tlsp_top.sv ----
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
// Contract
// [RULE1] The modulation boundary byte is the index threshold for placing recalled modulation bytes.
// [RULE2] The first auxiliary boundary byte is the threshold for that output's table placement.
// [RULE3] The second auxiliary boundary byte is the threshold for that output's table placement.
// [RULE4] Auxiliary boundaries are compared with the adjusted recall address, not the raw index.
// [RULE5] An index above the step boundary selects the high bias step, below it the low step.
// [RULE6] With modulation polarity 0, below boundary goes to the low byte, otherwise the high byte.
// [RULE7] With modulation polarity 1, below boundary goes to the high byte, otherwise the low byte.
// [RULE8] Polarity bit 6 sets, and at 1 reverses, the first auxiliary output's byte placement.
// [RULE9] Polarity bit 5 sets, and at 1 reverses, the second auxiliary output's byte placement.
// [RULE10] Reads need the higher level or lower level with a grant; writes need higher or lower with rw grant.
// [RULE11] An index equal to the step boundary selects the low bias step.
module tlsp_top
	import tlsp_pkg::*;
#(
	parameter int STEP_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// password state from the access logic
	input wire logic higher_password_level_i,
	input wire logic lower_password_level_i,
	input wire logic low_level_table_rw_grant_i,
	input wire logic low_level_table_read_grant_i,
	// table recall
	input wire logic recall_i,
	input wire logic [1:0] recall_dest_i,
	input wire logic [7:0] recall_addr_i,
	input wire logic [7:0] recall_data_i,
	input wire logic [7:0] temperature_table_index_i,
	// bias step values
	input wire logic [STEP_W-1:0] bias_step_high_value_i,
	input wire logic [STEP_W-1:0] bias_step_low_value_i,
	// results
	output logic [15:0] modulation_o,
	output logic [15:0] aux_analog_out_one_o,
	output logic [15:0] aux_analog_out_two_o,
	output logic [STEP_W-1:0] active_bias_step_o
);
	// ******************************************
	// registers
	// ******************************************
	logic [7:0] modulation_temp_boundary_r;
	logic [7:0] aux_out_one_temp_boundary_r;
	logic [7:0] aux_out_two_temp_boundary_r;
	logic [7:0] bias_step_temp_boundary_r;
	logic [7:0] table_polarity_select_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] dat_nxt;
	logic [7:0] reg_idx;
	logic rd_ok;
	logic wr_ok;
	logic wr_take;
	logic req;
	logic step_high;
	logic [TLSP_NUM_DEST-1:0] placed_upper;
	logic [TLSP_NUM_DEST-1:0] store;
	logic [7:0] compare_val [TLSP_NUM_DEST];
	logic [7:0] boundary_val [TLSP_NUM_DEST];
	logic [TLSP_NUM_DEST-1:0] polarity_val;
	logic [15:0] dest_val [TLSP_NUM_DEST];

	// decodes a byte index into the register it names
	function automatic logic is_reg(input logic [7:0] idx, input logic [7:0] want);
		is_reg = (idx == want);
	endfunction : is_reg

	// ******************************************
	// access permission
	// ******************************************
	// lower level alone opens nothing; a grant must accompany it
	assign rd_ok = higher_password_level_i
		| (lower_password_level_i & (low_level_table_rw_grant_i | low_level_table_read_grant_i)); // [RULE10]
	assign wr_ok = higher_password_level_i | (lower_password_level_i & low_level_table_rw_grant_i); // [RULE10]

	// ******************************************
	// wishbone slave
	// ******************************************
	assign reg_idx = adr_i[9:2];
	assign req = cyc_i & stb_i;
	// write lands on the edge where the master sees ack, lane 0 only
	assign wr_take = req & ack_r & we_i & sel_i[0] & wr_ok; // [RULE10]
	assign ack_o = ack_r;
	assign dat_o = dat_r;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// read mux; denied or unmapped reads give zero
	always_comb begin
		dat_nxt = 32'h0000_0000;
		if (rd_ok) begin // [RULE10]
			unique case (1'b1)
				is_reg(reg_idx, TLSP_IDX_MOD_BND): dat_nxt[7:0] = modulation_temp_boundary_r;
				is_reg(reg_idx, TLSP_IDX_AUX1_BND): dat_nxt[7:0] = aux_out_one_temp_boundary_r;
				is_reg(reg_idx, TLSP_IDX_AUX2_BND): dat_nxt[7:0] = aux_out_two_temp_boundary_r;
				is_reg(reg_idx, TLSP_IDX_STEP_BND): dat_nxt[7:0] = bias_step_temp_boundary_r;
				is_reg(reg_idx, TLSP_IDX_POLARITY): dat_nxt[7:0] = table_polarity_select_r & TLSP_POL_WR_MASK;
				is_reg(reg_idx, TLSP_IDX_STATUS): begin
					dat_nxt[TLSP_STAT_STEP_BIT] = step_high;
					dat_nxt[TLSP_STAT_UPPER_LSB +: TLSP_NUM_DEST] = placed_upper;
				end
				default: dat_nxt = 32'h0000_0000;
			endcase
		end
	end

	// read data is captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (req & ~ack_r & ~we_i) begin
			dat_r <= dat_nxt;
		end else if (~req) begin
			dat_r <= 32'h0000_0000;
		end
	end

	// ******************************************
	// boundary and polarity registers
	// ******************************************
	// boundaries are written by software in the offset-80h index encoding
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			modulation_temp_boundary_r <= TLSP_RST_BND;
			aux_out_one_temp_boundary_r <= TLSP_RST_BND;
			aux_out_two_temp_boundary_r <= TLSP_RST_BND;
			bias_step_temp_boundary_r <= TLSP_RST_BND;
		end else if (wr_take) begin
			if (is_reg(reg_idx, TLSP_IDX_MOD_BND)) begin
				modulation_temp_boundary_r <= dat_i[7:0]; // [RULE1]
			end
			if (is_reg(reg_idx, TLSP_IDX_AUX1_BND)) begin
				aux_out_one_temp_boundary_r <= dat_i[7:0]; // [RULE2]
			end
			if (is_reg(reg_idx, TLSP_IDX_AUX2_BND)) begin
				aux_out_two_temp_boundary_r <= dat_i[7:0]; // [RULE3]
			end
			if (is_reg(reg_idx, TLSP_IDX_STEP_BND)) begin
				bias_step_temp_boundary_r <= dat_i[7:0]; // [RULE5]
			end
		end
	end

	// only the three polarity bits store; the rest stay zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			table_polarity_select_r <= TLSP_RST_POLARITY;
		end else if (wr_take && is_reg(reg_idx, TLSP_IDX_POLARITY)) begin
			table_polarity_select_r <= dat_i[7:0] & TLSP_POL_WR_MASK;
		end
	end

	// ******************************************
	// recall placement
	// ******************************************
	// modulation compares the raw index, auxiliaries the adjusted address
	assign compare_val[TLSP_DEST_MOD] = temperature_table_index_i; // [RULE1]
	assign compare_val[TLSP_DEST_AUX1] = recall_addr_i; // [RULE4]
	assign compare_val[TLSP_DEST_AUX2] = recall_addr_i; // [RULE4]
	assign boundary_val[TLSP_DEST_MOD] = modulation_temp_boundary_r; // [RULE1]
	assign boundary_val[TLSP_DEST_AUX1] = aux_out_one_temp_boundary_r; // [RULE2]
	assign boundary_val[TLSP_DEST_AUX2] = aux_out_two_temp_boundary_r; // [RULE3]
	assign polarity_val[TLSP_DEST_MOD] = table_polarity_select_r[TLSP_POL_MOD_BIT]; // [RULE7]
	assign polarity_val[TLSP_DEST_AUX1] = table_polarity_select_r[TLSP_POL_AUX1_BIT]; // [RULE8]
	assign polarity_val[TLSP_DEST_AUX2] = table_polarity_select_r[TLSP_POL_AUX2_BIT]; // [RULE9]

	// one placement unit per destination register
	generate
		for (genvar g = 0; g < TLSP_NUM_DEST; g++) begin : g_place
			assign store[g] = recall_i & (recall_dest_i == 2'(g));
			tlsp_place u_place (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.store_i(store[g]),
				.value_i(recall_data_i),
				.compare_i(compare_val[g]),
				.boundary_i(boundary_val[g]),
				.polarity_i(polarity_val[g]),
				.dest_o(dest_val[g]),
				.upper_o(placed_upper[g])
			);
		end
	endgenerate

	assign modulation_o = dest_val[TLSP_DEST_MOD];
	assign aux_analog_out_one_o = dest_val[TLSP_DEST_AUX1];
	assign aux_analog_out_two_o = dest_val[TLSP_DEST_AUX2];

	// ******************************************
	// bias step selection
	// ******************************************
	tlsp_step_sel #(
		.STEP_W(STEP_W)
	) u_step (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.index_i(temperature_table_index_i),
		.boundary_i(bias_step_temp_boundary_r),
		.high_i(bias_step_high_value_i),
		.low_i(bias_step_low_value_i),
		.step_o(active_bias_step_o),
		.high_sel_o(step_high)
	);

	// ******************************************
	// checks
	// ******************************************
	ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_r |=> !ack_r)
		else $error("ack held for two cycles");
	wr_denied_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
		req && ack_r && we_i && !wr_ok |=> $stable(modulation_temp_boundary_r)
		&& $stable(table_polarity_select_r) && $stable(bias_step_temp_boundary_r))
		else $error("write stored without permission");
	rd_denied_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
		req && !ack_r && !we_i && !rd_ok |=> dat_o == 32'h0000_0000)
		else $error("read data returned without permission");
	mod_boundary_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
		wr_take && is_reg(reg_idx, TLSP_IDX_MOD_BND) |=> modulation_temp_boundary_r == $past(dat_i[7:0]))
		else $error("modulation boundary not stored");
	aux_uses_addr_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
		store[TLSP_DEST_AUX1] && !polarity_val[TLSP_DEST_AUX1] && recall_addr_i >= aux_out_one_temp_boundary_r
		|=> aux_analog_out_one_o[15:8] == $past(recall_data_i))
		else $error("aux one placement ignores recall address");
	aux_two_rev_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
		store[TLSP_DEST_AUX2] && polarity_val[TLSP_DEST_AUX2] && recall_addr_i < aux_out_two_temp_boundary_r
		|=> aux_analog_out_two_o[15:8] == $past(recall_data_i))
		else $error("aux two reversed placement wrong");
	mod_neg_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
		store[TLSP_DEST_MOD] && polarity_val[TLSP_DEST_MOD]
		&& temperature_table_index_i >= modulation_temp_boundary_r
		|=> modulation_o[7:0] == $past(recall_data_i))
		else $error("negative modulation placement wrong");
	pol_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
		table_polarity_select_r[4:0] == 5'h00)
		else $error("reserved polarity bits set");

	// ******************************************
	// handshake, read path and write lane checks
	// ******************************************
	// every request is answered on the next edge
	ack_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !ack_r |=> ack_r)
		else $error("request not acknowledged");
	// read data falls back to zero between requests
	dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> dat_o == 32'h0000_0000)
		else $error("read data left standing");
	// a granted read of the modulation boundary returns its stored byte
	rd_value_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
		req && !ack_r && !we_i && rd_ok && is_reg(reg_idx, TLSP_IDX_MOD_BND)
		|=> dat_o == {24'h000000, $past(modulation_temp_boundary_r)})
		else $error("granted read returned wrong data");
	// a write without the low byte lane stores nothing
	lane_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req && ack_r && we_i && !sel_i[0] |=> $stable(aux_out_one_temp_boundary_r)
		&& $stable(aux_out_two_temp_boundary_r) && $stable(modulation_temp_boundary_r))
		else $error("write stored without low lane");

	// ******************************************
	// register store checks
	// ******************************************
	aux1_boundary_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
		wr_take && is_reg(reg_idx, TLSP_IDX_AUX1_BND)
		|=> aux_out_one_temp_boundary_r == $past(dat_i[7:0]))
		else $error("aux one boundary not stored");
	aux2_boundary_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
		wr_take && is_reg(reg_idx, TLSP_IDX_AUX2_BND)
		|=> aux_out_two_temp_boundary_r == $past(dat_i[7:0]))
		else $error("aux two boundary not stored");
	step_boundary_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
		wr_take && is_reg(reg_idx, TLSP_IDX_STEP_BND)
		|=> bias_step_temp_boundary_r == $past(dat_i[7:0]))
		else $error("step boundary not stored");
	// only the three polarity bits take the written value
	pol_store_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8] [RULE9]
		wr_take && is_reg(reg_idx, TLSP_IDX_POLARITY)
		|=> table_polarity_select_r == ($past(dat_i[7:0]) & TLSP_POL_WR_MASK))
		else $error("polarity bits not stored");

	// ******************************************
	// placement checks
	// ******************************************
	mod_pos_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		store[TLSP_DEST_MOD] && !polarity_val[TLSP_DEST_MOD]
		&& temperature_table_index_i >= modulation_temp_boundary_r
		|=> modulation_o[15:8] == $past(recall_data_i))
		else $error("positive modulation upper placement wrong");
	mod_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		store[TLSP_DEST_MOD] && !polarity_val[TLSP_DEST_MOD]
		&& temperature_table_index_i < modulation_temp_boundary_r
		|=> modulation_o[7:0] == $past(recall_data_i))
		else $error("positive modulation lower placement wrong");
	aux_one_rev_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		store[TLSP_DEST_AUX1] && polarity_val[TLSP_DEST_AUX1] && recall_addr_i >= aux_out_one_temp_boundary_r
		|=> aux_analog_out_one_o[7:0] == $past(recall_data_i))
		else $error("aux one reversed placement wrong");
	aux_two_fwd_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
		store[TLSP_DEST_AUX2] && !polarity_val[TLSP_DEST_AUX2] && recall_addr_i < aux_out_two_temp_boundary_r
		|=> aux_analog_out_two_o[7:0] == $past(recall_data_i))
		else $error("aux two forward placement wrong");
	// the unused destination code leaves every output alone
	dest_unused_a: assert property (@(posedge clk_i) disable iff (rst_i)
		recall_i && recall_dest_i == 2'd3
		|=> $stable(modulation_o) && $stable(aux_analog_out_one_o) && $stable(aux_analog_out_two_o))
		else $error("recall to unused destination stored");

	cov_write_c: cover property (@(posedge clk_i) disable iff (rst_i) wr_take);
	cov_read_c: cover property (@(posedge clk_i) disable iff (rst_i) req && ack_r && !we_i && rd_ok);
	cov_aux_c: cover property (@(posedge clk_i) disable iff (rst_i) store[TLSP_DEST_AUX2]);
endmodule : tlsp_top
